// ---- rtl/pcrm_pkg.sv ----
// package of constants for the power, clock-rate and reset manager
package pcrm_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] PMR_OFS    = 4'h0;  // power_management_reg
  localparam logic [3:0] EXTENDED_INTERRUPT_FLAG_REG_OFS   = 4'h4;  // extended_interrupt_flag_reg
  localparam logic [3:0] POWER_CONTROL_REG_OFS   = 4'h8;  // power_control_reg
  localparam logic [3:0] STAT_OFS   = 4'hC;  // status and reset-source flags
  // field positions
  localparam int PMR_CD_LO  = 6;
  localparam int PMR_CD_HI  = 7;
  localparam int PMR_SWB    = 5;
  localparam int PMR_XOFF   = 3;
  localparam int EXTENDED_INTERRUPT_FLAG_REG_SRC   = 3;
  localparam int EXTENDED_INTERRUPT_FLAG_REG_RCACT = 2;
  localparam int EXTENDED_INTERRUPT_FLAG_REG_RGSEL = 1;
  localparam int POWER_CONTROL_REG_IDLE  = 0;
  localparam int POWER_CONTROL_REG_PD    = 1;
  localparam int STAT_XRDY  = 4;
  localparam int STAT_POR   = 6;
  localparam int STAT_WATCHDOG_RESET_FLAG  = 2;
  // divider encodings
  localparam logic [1:0] CD_RSVD = 2'h0;
  localparam logic [1:0] CD_4    = 2'h1;
  localparam logic [1:0] CD_64   = 2'h2;
  localparam logic [1:0] CD_1024 = 2'h3;
  localparam logic [10:0] DIV_4    = 11'h004;
  localparam logic [10:0] DIV_64   = 11'h040;
  localparam logic [10:0] DIV_1024 = 11'h400;
  // timing counts
  localparam int MC_RESET_HOLD = 2;    // machine cycles of reset hold
  localparam int WD_DELAY_CLK  = 512;  // clocks from timeout to reset
  localparam int XTAL_WARM_CLK = 1024; // crystal warm-up clocks
  localparam int ISTATE_C4     = 3;    // clock index of state C4
  // reset values
  localparam logic [7:0] SP_RESET   = 8'h07;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [15:0] PC_RESET  = 16'h0000;
endpackage

// ---- rtl/pcrm_top.sv ----
// power, clock-rate and reset manager with wishbone register access
`timescale 1ns/1ps
`default_nettype none
module pcrm_top
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // pins and events
  input  wire logic        i_por,
  input  wire logic        i_rst_pin,
  input  wire logic        i_wd_timeout,
  input  wire logic        i_wd_clear,
  input  wire logic        i_wd_reset_en,
  input  wire logic        i_rx_start_fall,
  input  wire logic        i_rx_enable,
  input  wire logic        i_sbuf_write,
  input  wire logic        i_serial_busy,
  input  wire logic        i_ext_int_ack,
  input  wire logic        i_ext_int_low,
  input  wire logic        i_ext_int_level_en,
  input  wire logic        i_global_interrupt_enable,
  input  wire logic        i_int_pending,
  input  wire logic        i_ext_prog_mem,
  // outputs
  output logic             o_core_ce,
  output logic             o_periph_ce,
  output logic             o_core_rst,
  output logic             o_osc_run,
  output logic             o_use_crystal,
  output logic             o_crystal_amp_off,
  output logic             o_ale,
  output logic             o_program_store_strobe,
  output logic             o_port0_oe,
  output logic             o_port2_addr,
  output logic      [15:0] o_pc_reset,
  output logic      [7:0]  o_sp_reset,
  output logic      [7:0]  o_port_reset,
  output logic             o_wd_disable
);
  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [1:0]  div_sel_r;      // software view of divider field
  logic [1:0]  div_act_r;      // divider in force
  logic        div_pend_r;
  logic        switchback_enable_r;
  logic        crystal_amp_off_r;
  logic        clock_source_select_r;
  logic        src_act_r;      // 1: crystal active
  logic        src_pend_r;
  logic        rc_wakeup_select_r;
  logic        idle_r;
  logic        pd_r;
  logic        crystal_ready_r;
  logic [10:0] xwarm_r;
  logic        por_flag_r;
  logic        watchdog_reset_flag_r;
  logic [10:0] clk_cnt_r;
  logic [10:0] div_val;
  logic        mc_end;
  logic        c4_tick;
  logic        rst_s1_r;
  logic        rst_s2_r;
  logic        rst_seen_r;
  logic [1:0]  hold_cnt_r;
  logic        wd_arm_r;
  logic [9:0]  wd_cnt_r;
  logic        wd_fire;
  logic        any_rst;
  logic        wr;
  logic        rd;
  logic        switchback;
  logic        wake_int;
  // wishbone decode
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack & i_wb_sel[0];
  assign rd = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // reset from any source
  assign any_rst = ~i_rst_b | i_por | (hold_cnt_r != 2'd0) | rst_s2_r;
  ////////////////////////////////////////////////////////////////////////
  // machine-cycle divider
  always_comb
  begin
    case (div_act_r)
      pcrm_pkg::CD_64:   div_val = pcrm_pkg::DIV_64;
      pcrm_pkg::CD_1024: div_val = pcrm_pkg::DIV_1024;
      default:           div_val = pcrm_pkg::DIV_4;
    endcase
  end
  assign mc_end  = (clk_cnt_r == div_val - 11'd1) & ~pd_r;
  assign c4_tick = (clk_cnt_r == 11'(pcrm_pkg::ISTATE_C4)) & ~pd_r;
  // clock-per-machine-cycle counter, stopped in power-down
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b || pd_r || mc_end)
      clk_cnt_r <= 11'h000;
    else
      clk_cnt_r <= clk_cnt_r + 11'd1;
  end
  // core and peripheral enables
  assign o_core_ce   = mc_end & ~idle_r & ~any_rst;
  assign o_periph_ce = idle_r ? (clk_cnt_r[1:0] == 2'h3) & ~pd_r
                              : mc_end;
  ////////////////////////////////////////////////////////////////////////
  // switchback triggers
  assign switchback = switchback_enable_r &
    ((i_rx_start_fall & i_rx_enable) | i_sbuf_write | i_ext_int_ack);
  // divider select write, pending apply at the next machine-cycle end
  always_ff @(posedge i_mclk)
  begin
    if (any_rst)
    begin
      div_sel_r  <= pcrm_pkg::CD_4;
      div_act_r  <= pcrm_pkg::CD_4;
      div_pend_r <= 1'b0;
    end
    else if (switchback)
    begin
      div_sel_r  <= pcrm_pkg::CD_4;
      div_act_r  <= pcrm_pkg::CD_4;
      div_pend_r <= 1'b0;
    end
    else if (wr && i_wb_adr == pcrm_pkg::PMR_OFS &&
             !(switchback_enable_r && i_serial_busy) &&
             i_wb_dat[7:6] != pcrm_pkg::CD_RSVD)
    begin
      div_sel_r  <= i_wb_dat[7:6];
      div_pend_r <= 1'b1;
    end
    else if (div_pend_r && mc_end)
    begin
      div_act_r  <= div_sel_r;
      div_pend_r <= 1'b0;
    end
  end
  // other power-management bits
  always_ff @(posedge i_mclk)
  begin
    if (any_rst)
    begin
      switchback_enable_r <= 1'b0;
      crystal_amp_off_r   <= 1'b0;
    end
    else if (wr && i_wb_adr == pcrm_pkg::PMR_OFS)
    begin
      switchback_enable_r <= i_wb_dat[pcrm_pkg::PMR_SWB];
      crystal_amp_off_r   <= i_wb_dat[pcrm_pkg::PMR_XOFF] & ~src_act_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // crystal warm-up counter
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b || crystal_amp_off_r)
    begin
      xwarm_r         <= 11'h000;
      crystal_ready_r <= 1'b0;
    end
    else if (xwarm_r == 11'(pcrm_pkg::XTAL_WARM_CLK))
      crystal_ready_r <= 1'b1;
    else
      xwarm_r <= xwarm_r + 11'd1;
  end
  // clock source select and delayed switch
  always_ff @(posedge i_mclk)
  begin
    if (any_rst)
    begin
      clock_source_select_r <= 1'b1;
      src_act_r             <= 1'b1;
      src_pend_r            <= 1'b0;
      rc_wakeup_select_r    <= 1'b0;
    end
    else if (wr && i_wb_adr == pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS)
    begin
      // crystal cannot be chosen before it is ready
      if (!i_wb_dat[pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_SRC] || crystal_ready_r)
      begin
        clock_source_select_r <= i_wb_dat[pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_SRC];
        src_pend_r            <= 1'b1;
      end
      rc_wakeup_select_r <= i_wb_dat[pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_RGSEL];
    end
    else if (pd_r && wake_int && rc_wakeup_select_r)
    begin
      src_act_r             <= 1'b0;
      clock_source_select_r <= 1'b1;
      src_pend_r            <= 1'b1;
    end
    else if (src_pend_r && mc_end &&
             (!clock_source_select_r || crystal_ready_r))
    begin
      src_act_r  <= clock_source_select_r;
      src_pend_r <= 1'b0;
    end
  end
  assign o_use_crystal     = src_act_r;
  assign o_crystal_amp_off = crystal_amp_off_r;
  ////////////////////////////////////////////////////////////////////////
  // idle and power-down
  assign wake_int = i_ext_int_low & i_ext_int_level_en &
                    i_global_interrupt_enable;
  always_ff @(posedge i_mclk)
  begin
    if (any_rst)
    begin
      idle_r <= 1'b0;
      pd_r   <= 1'b0;
    end
    else
    begin
      if (wr && i_wb_adr == pcrm_pkg::POWER_CONTROL_REG_OFS && i_wb_dat[pcrm_pkg::POWER_CONTROL_REG_PD])
        pd_r <= 1'b1;
      else if (wake_int)
        pd_r <= 1'b0;
      if (wr && i_wb_adr == pcrm_pkg::POWER_CONTROL_REG_OFS &&
          i_wb_dat[pcrm_pkg::POWER_CONTROL_REG_IDLE])
        idle_r <= 1'b1;
      else if (i_int_pending)
        idle_r <= 1'b0;
    end
  end
  assign o_osc_run = ~pd_r;
  // strobes and port states
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_ale                  <= 1'b1;
      o_program_store_strobe <= 1'b1;
      o_port0_oe             <= 1'b1;
      o_port2_addr           <= 1'b0;
    end
    else
    begin
      o_ale                  <= ~pd_r;
      o_program_store_strobe <= ~pd_r;
      o_port0_oe             <= ~((pd_r | idle_r) & i_ext_prog_mem);
      o_port2_addr           <= idle_r & ~pd_r & i_ext_prog_mem;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= i_rst_pin;
      rst_s2_r <= rst_s1_r;
    end
  end
  // sample pin at c4, or at once in power-down; hold after release
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b || i_por)
    begin
      rst_seen_r <= 1'b0;
      hold_cnt_r <= 2'(pcrm_pkg::MC_RESET_HOLD);
    end
    else if ((c4_tick || pd_r) && rst_s2_r)
    begin
      rst_seen_r <= 1'b1;
      hold_cnt_r <= 2'(pcrm_pkg::MC_RESET_HOLD);
    end
    else if (wd_fire)
      hold_cnt_r <= 2'(pcrm_pkg::MC_RESET_HOLD);
    else if (mc_end && hold_cnt_r != 2'd0)
    begin
      hold_cnt_r <= hold_cnt_r - 2'd1;
      rst_seen_r <= 1'b0;
    end
  end
  // watchdog delay from timeout flag to reset
  always_ff @(posedge i_mclk)
  begin
    if (any_rst || i_wd_clear || pd_r)
    begin
      wd_arm_r <= 1'b0;
      wd_cnt_r <= 10'h000;
    end
    else if (i_wd_timeout && i_wd_reset_en && !wd_arm_r)
      wd_arm_r <= 1'b1;
    else if (wd_arm_r)
      wd_cnt_r <= wd_cnt_r + 10'd1;
  end
  assign wd_fire = wd_arm_r &
                   (wd_cnt_r == 10'(pcrm_pkg::WD_DELAY_CLK - 1));
  // reset source flags
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b || i_por)
    begin
      por_flag_r            <= 1'b1;
      watchdog_reset_flag_r <= 1'b0;
    end
    else if (wd_fire)
      watchdog_reset_flag_r <= 1'b1;
    else if (wr && i_wb_adr == pcrm_pkg::STAT_OFS)
    begin
      por_flag_r            <= i_wb_dat[pcrm_pkg::STAT_POR];
      watchdog_reset_flag_r <= i_wb_dat[pcrm_pkg::STAT_WATCHDOG_RESET_FLAG];
    end
  end
  // reset outputs and reset-state values
  assign o_core_rst   = any_rst;
  assign o_pc_reset   = pcrm_pkg::PC_RESET;
  assign o_sp_reset   = pcrm_pkg::SP_RESET;
  assign o_port_reset = pcrm_pkg::PORT_RESET;
  assign o_wd_disable = i_por | ~i_rst_b;
  ////////////////////////////////////////////////////////////////////////
  // wishbone read data and ack
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= rd;
      o_wb_dat <= 32'h00000000;
      if (rd && i_wb_adr == pcrm_pkg::PMR_OFS)
        o_wb_dat[7:0] <= {div_sel_r, switchback_enable_r, 1'b0,
                          crystal_amp_off_r, 3'h0};
      else if (rd && i_wb_adr == pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS)
        o_wb_dat[7:0] <= {4'h0, clock_source_select_r, ~src_act_r,
                          rc_wakeup_select_r, 1'b0};
      else if (rd && i_wb_adr == pcrm_pkg::POWER_CONTROL_REG_OFS)
        o_wb_dat[7:0] <= {6'h00, pd_r, idle_r};
      else if (rd && i_wb_adr == pcrm_pkg::STAT_OFS)
        o_wb_dat[7:0] <= {1'b0, por_flag_r, 1'b0, crystal_ready_r,
                          1'b0, watchdog_reset_flag_r, 2'h0};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence wd_armed_s;
    !wd_arm_r ##1 wd_arm_r;
  endsequence
  chk_div_reset_four: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    any_rst |=> div_act_r == pcrm_pkg::CD_4)
    else $error("divider not four after reset");
  chk_rsvd_ignored: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    div_act_r != pcrm_pkg::CD_RSVD)
    else $error("reserved divider in force");
  chk_switchback_now: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    switchback |=> div_act_r == pcrm_pkg::CD_4)
    else $error("switchback did not restore four");
  chk_xtal_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(src_act_r) |-> crystal_ready_r)
    else $error("crystal active before ready");
  chk_pd_strobes: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pd_r |=> !o_ale && !o_program_store_strobe)
    else $error("strobes high in power-down");
  chk_pd_clock_stop: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    pd_r |-> !o_core_ce && !o_osc_run)
    else $error("clock running in power-down");
  chk_wd_delay: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wd_armed_s ##0 (!i_wd_clear && !any_rst && !pd_r) [*1]
    |-> ##[1:520] (wd_fire || i_wd_clear || any_rst || pd_r))
    else $error("watchdog reset late");
  chk_watchdog_reset_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wd_fire |=> watchdog_reset_flag_r && o_core_rst)
    else $error("watchdog flag not set");
  chk_delayed_div: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $changed(div_act_r) |-> $past(mc_end) || $past(any_rst) ||
                            $past(switchback))
    else $error("divider changed off boundary");
endmodule
`default_nettype wire

// ---- sim/pcrm_top_tb_top.sv ----
// self-checking bench for the power, clock-rate and reset manager
`timescale 1ns/1ps
`default_nettype none
module pcrm_top_tb_top;
  // design inputs
  logic        i_mclk, i_rst_b, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [3:0]  i_wb_adr, i_wb_sel;
  logic [31:0] i_wb_dat;
  logic        i_por, i_rst_pin, i_wd_timeout, i_wd_clear, i_wd_reset_en;
  logic        i_rx_start_fall, i_rx_enable, i_sbuf_write, i_serial_busy;
  logic        i_ext_int_ack, i_ext_int_low, i_ext_int_level_en;
  logic        i_global_interrupt_enable, i_int_pending, i_ext_prog_mem;
  // design outputs
  logic [31:0] o_wb_dat;
  logic        o_wb_ack, o_core_ce, o_periph_ce, o_core_rst, o_osc_run;
  logic        o_use_crystal, o_crystal_amp_off, o_ale, o_wd_disable;
  logic        o_program_store_strobe, o_port0_oe, o_port2_addr;
  logic [15:0] o_pc_reset;
  logic [7:0]  o_sp_reset, o_port_reset;
  // bench state
  int          failures, checks_done, n;
  logic [31:0] rd, seed;
  logic [1:0]  cur, dv;
  logic [1:0]  tbl [5];

  pcrm_top u_pcrm_top (.*);

  // free-running 100 MHz clock
  initial
  begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // closing report, comparison and helpers
  task automatic wrap_up();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return o_core_ce;
      1: return o_periph_ce;
      2: return o_osc_run;
      3: return ~o_osc_run;
      4: return o_core_rst;
      5: return ~o_core_rst;
      default: return o_use_crystal;
    endcase
  endfunction

  // expected divider after a write: reserved code keeps the old one
  function automatic logic [1:0] nxt_div(input logic [1:0] c,
                                         input logic [1:0] w);
    return (w == pcrm_pkg::CD_RSVD) ? c : w;
  endfunction

  // clocks per machine cycle for an encoding
  function automatic int gap_of(input logic [1:0] c);
    return 4 << (4 * (c - 1));
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // count edges until the chosen output is seen high, bounded
  task automatic wt(input int k, output int c);
    c = 0;
    do
    begin
      @(posedge i_mclk);
      c++;
    end
    while (sig(k) !== 1'h1 && c < 3000);
    if (c >= 3000)
    begin
      failures++;
      wrap_up();
    end
  endtask

  // spacing of pulses once the new rate has settled
  task automatic gap(input int k, output int c);
    wt(k, c);
    wt(k, c);
    wt(k, c);
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int c;
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we  <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h000000, d};
    c = 0;
    do
    begin
      @(posedge i_mclk);
      c++;
    end
    while (o_wb_ack !== 1'h1 && c < 50);
    if (c >= 50)
    begin
      failures++;
      wrap_up();
    end
    rd = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial
  begin
    #950000;
    failures++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} = '0;
    {i_por, i_rst_pin, i_wd_timeout, i_wd_clear, i_wd_reset_en} = '0;
    {i_rx_start_fall, i_rx_enable, i_sbuf_write, i_serial_busy} = '0;
    {i_ext_int_ack, i_ext_int_low, i_ext_int_level_en} = '0;
    {i_global_interrupt_enable, i_int_pending} = '0;
    i_ext_prog_mem = 1'h1;
    i_wb_sel = 4'hF;
    i_rst_b = 1'h0;
    failures = 0;
    checks_done = 0;
    seed = 32'h00000032;
    cur = pcrm_pkg::CD_4;
    tbl = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1};
    repeat (3) @(posedge i_mclk);
    check("rst_core", o_core_rst, 1'h1);
    check("rst_pins", {o_ale, o_program_store_strobe}, 2'h3);
    check("rst_vals", {o_pc_reset, o_sp_reset, o_port_reset}, 32'h07FF);
    i_rst_b <= 1'h1;
    wt(5, n);
    check("rst_tail", n <= 12, 1'h1);
    wb(1'h0, pcrm_pkg::PMR_OFS, 8'h00);
    check("div_default", rd[7:6], pcrm_pkg::CD_4);
    wb(1'h0, 4'h6, 8'h00);
    check("unmapped", rd, 32'h0);
    // divider corner table, then random settings
    for (int i = 0; i < 11; i++)
    begin
      seed = xs(seed);
      if (i < 5)
        dv = tbl[i];
      else
        dv = seed[1:0];
      if (cur[1] && dv[1] && dv != cur)
      begin
        wb(1'h1, pcrm_pkg::PMR_OFS, 8'h40);
        wt(0, n);
        cur = pcrm_pkg::CD_4;
      end
      wb(1'h1, pcrm_pkg::PMR_OFS, {dv, 6'h00});
      cur = nxt_div(cur, dv);
      wb(1'h0, pcrm_pkg::PMR_OFS, 8'h00);
      check("div_field", rd[7:6], cur);
      gap(0, n);
      check("core_gap", n, gap_of(cur));
      gap(1, n);
      check("periph_gap", n, gap_of(cur));
    end
    // switchback triggers; the last one has reception disabled
    for (int k = 0; k < 4; k++)
    begin
      if (cur == pcrm_pkg::CD_1024)
      begin
        wb(1'h1, pcrm_pkg::PMR_OFS, 8'h40);
        wt(0, n);
      end
      wb(1'h1, pcrm_pkg::PMR_OFS, 8'hA0);
      cur = pcrm_pkg::CD_64;
      i_rx_enable <= (k != 3);
      case (k)
        0: i_sbuf_write <= 1'h1;
        2: i_ext_int_ack <= 1'h1;
        default: i_rx_start_fall <= 1'h1;
      endcase
      @(posedge i_mclk);
      {i_sbuf_write, i_rx_start_fall, i_ext_int_ack} <= 3'h0;
      repeat (2) @(posedge i_mclk);
      wb(1'h0, pcrm_pkg::PMR_OFS, 8'h00);
      check("switchback", rd[7:6], (k == 3) ? 2'h2 : 2'h1);
    end
    // divider writes are ignored while the serial port is busy and switchback is enabled
    i_serial_busy <= 1'h1;
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h60);
    wb(1'h0, pcrm_pkg::PMR_OFS, 8'h00);
    check("busy_ignore", rd[7:6], 2'h2);
    i_serial_busy <= 1'h0;
    // crystal select refused until the amplifier has warmed up
    // the amplifier may only be turned off once rc is the active source
    wb(1'h1, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, 8'h00);
    wt(0, n);
    wt(0, n);
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h48);
    wb(1'h0, pcrm_pkg::STAT_OFS, 8'h00);
    check("xrdy_off", rd[pcrm_pkg::STAT_XRDY], 1'h0);
    wb(1'h1, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, 8'h08);
    wb(1'h0, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, 8'h00);
    check("src_refused", rd[pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_SRC], 1'h0);
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h40);
    repeat (pcrm_pkg::XTAL_WARM_CLK + 8) @(posedge i_mclk);
    wb(1'h0, pcrm_pkg::STAT_OFS, 8'h00);
    check("xrdy_on", rd[pcrm_pkg::STAT_XRDY], 1'h1);
    for (int s = 1; s >= 0; s--)
    begin
      wb(1'h1, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, s ? 8'h08 : 8'h00);
      wt(0, n);
      wt(0, n);
      check("src_pin", o_use_crystal, s);
      wb(1'h0, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, 8'h00);
      check("rc_active", rd[pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_RCACT], !s);
    end
    // idle at divide-by-64: peripherals stay at clock/4
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h80);
    wb(1'h1, pcrm_pkg::POWER_CONTROL_REG_OFS, 8'h01);
    gap(1, n);
    check("idle_periph", n, 4);
    check("idle_pins", {o_ale, o_program_store_strobe, o_port0_oe,
                        o_port2_addr}, 4'hD);
    n = 0;
    repeat (200)
    begin
      @(posedge i_mclk);
      n += o_core_ce;
    end
    check("idle_core", n, 0);
    i_int_pending <= 1'h1;
    wt(0, n);
    i_int_pending <= 1'h0;
    wb(1'h0, pcrm_pkg::POWER_CONTROL_REG_OFS, 8'h00);
    check("idle_clr", rd[pcrm_pkg::POWER_CONTROL_REG_IDLE], 1'h0);
    // power-down with rc wakeup; the watchdog must not wake it
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h40);
    wb(1'h1, pcrm_pkg::EXTENDED_INTERRUPT_FLAG_REG_OFS, 8'h0A);
    wt(6, n);
    wb(1'h1, pcrm_pkg::POWER_CONTROL_REG_OFS, 8'h02);
    wt(3, n);
    @(posedge i_mclk);
    check("pd_pins", {o_ale, o_program_store_strobe, o_port0_oe}, 3'h0);
    {i_wd_reset_en, i_wd_timeout} <= 2'h3;
    repeat (600) @(posedge i_mclk);
    check("pd_wd", {o_osc_run, o_core_rst, o_core_ce}, 3'h0);
    {i_wd_reset_en, i_wd_timeout, i_wd_clear} <= 3'h1;
    @(posedge i_mclk);
    i_wd_clear <= 1'h0;
    {i_ext_int_low, i_ext_int_level_en, i_global_interrupt_enable} <= 3'h7;
    wt(2, n);
    @(posedge i_mclk);
    check("wake_rc", o_use_crystal, 1'h0);
    {i_ext_int_low, i_ext_int_level_en, i_global_interrupt_enable} <= 3'h0;
    wt(0, n);
    wt(6, n);
    // power-down ended by the reset pin, at divide-by-64
    wb(1'h1, pcrm_pkg::PMR_OFS, 8'h80);
    wb(1'h1, pcrm_pkg::POWER_CONTROL_REG_OFS, 8'h02);
    wt(3, n);
    i_rst_pin <= 1'h1;
    wt(4, n);
    @(posedge i_mclk);
    check("pd_rst", o_osc_run, 1'h1);
    repeat (8) @(posedge i_mclk);
    i_rst_pin <= 1'h0;
    wt(5, n);
    check("pin_tail", n <= 14, 1'h1);
    wb(1'h0, pcrm_pkg::PMR_OFS, 8'h00);
    check("rst_div", rd[7:6], pcrm_pkg::CD_4);
    // watchdog reset delay, hold and flag
    {i_wd_reset_en, i_wd_timeout} <= 2'h3;
    wt(4, n);
    check("wd_delay", n >= 510 && n <= 518, 1'h1);
    i_wd_timeout <= 1'h0;
    wt(5, n);
    check("wd_hold", n >= 7 && n <= 10, 1'h1);
    i_wd_reset_en <= 1'h0;
    wb(1'h0, pcrm_pkg::STAT_OFS, 8'h00);
    check("wd_flag", rd[pcrm_pkg::STAT_WATCHDOG_RESET_FLAG], 1'h1);
    // power-on reset sets its own flag and clears the watchdog one
    i_por <= 1'h1;
    repeat (4) @(posedge i_mclk);
    check("por_wd_off", o_wd_disable, 1'h1);
    i_por <= 1'h0;
    wt(5, n);
    wb(1'h0, pcrm_pkg::STAT_OFS, 8'h00);
    check("por_flags", {rd[pcrm_pkg::STAT_POR],
                        rd[pcrm_pkg::STAT_WATCHDOG_RESET_FLAG]}, 2'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
